// ### plcp_pkg.sv
// Purpose: shared constants and types of the pulse-length command port
// Assumes: 40 MHz system clock, 10 ms internal time base
// Notes:   times are kept in ms; sequencing times and the stuck limit become tick counts here, command windows in plcp_cmd_port
package plcp_pkg;

    // ------------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned NS_PER_MS = 1_000_000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // command pulse lengths in ms
    // ------------------------------------------------------------------
    localparam int unsigned CMD_TOL_MS = 100;
    localparam int unsigned CMD_PUMP1_MS = 2000;
    localparam int unsigned CMD_PUMP2_MS = 5000;
    localparam int unsigned CMD_BOTH_MS = 8000;
    localparam int unsigned CMD_FILL_MS = 12000;
    localparam int unsigned CMD_ACK_MS = 14000;
    localparam int unsigned CMD_STUCK_MS = 15000;

    // ------------------------------------------------------------------
    // sequencing times in ms
    // ------------------------------------------------------------------
    localparam int unsigned SELFCHK_MS = 2000;
    localparam int unsigned GAP_MS = 2000;
    localparam int unsigned HOLDOFF_MS = 3000;
    localparam int unsigned RUN_MAX_MS = 17000;

    // ------------------------------------------------------------------
    // tick counts (least times round up except hold-off, longest times round down)
    // ------------------------------------------------------------------
    localparam int unsigned SELFCHK_T = (SELFCHK_MS + TICK_MS - 1) / TICK_MS;
    localparam int unsigned GAP_T = (GAP_MS + TICK_MS - 1) / TICK_MS;
    localparam int unsigned HOLDOFF_T = HOLDOFF_MS / TICK_MS;
    localparam int unsigned RUN_MAX_T = RUN_MAX_MS / TICK_MS;
    localparam int unsigned LEN_MAX_T = CMD_STUCK_MS / TICK_MS + 1;
    localparam int LEN_W = 11;
    localparam int TMR_W = 11;
    localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(LEN_MAX_T);
    localparam logic [TMR_W-1:0] TMR_MAX = {TMR_W{1'b1}};

    // ------------------------------------------------------------------
    // stroke sequencing and cartridge bookkeeping
    // ------------------------------------------------------------------
    localparam int RUN_W = 7;
    localparam int unsigned FILL_RUNS_PER_BODY = 40;
    localparam logic [RUN_W-1:0] RUNS_SINGLE = 7'h01;
    localparam logic [RUN_W-1:0] RUNS_BOTH = 7'h02;
    localparam logic [RUN_W-1:0] RUNS_FILL = RUN_W'(2 * FILL_RUNS_PER_BODY);
    localparam int unsigned CART_UL = 400000;
    localparam int unsigned WARN_UL = 80000;
    localparam int unsigned STROKE_UL = 160;
    localparam int STK_W = 12;
    localparam logic [STK_W-1:0] WARN_STROKES =
        STK_W'((CART_UL - WARN_UL) / STROKE_UL);

    // decoded command codes
    typedef enum logic [2:0] {
        CMD_NONE, CMD_PUMP1, CMD_PUMP2, CMD_BOTH, CMD_FILL, CMD_ACK
    } plcp_cmd_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_SELFCHK, ST_READY, ST_RUN, ST_GAP, ST_HOLDOFF, ST_ERROR
    } plcp_state_t;

endpackage

// ### plcp_in_sync.sv
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: input is asynchronous to clk_i
// Notes:   output follows once stages two and three agree
module plcp_in_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin and clean level
    input wire logic pin_i,
    output logic lvl_o
);

    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic lvl_d;
    logic lvl_q;

    // ------------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chain
            if (g == 0) begin : g_first
                assign stage_d[g] = pin_i;
            end else begin : g_next
                assign stage_d[g] = stage_q[g-1];
            end
        end
    endgenerate

    // level changes only when the last two stages agree
    always_comb begin
        lvl_d = lvl_q;
        if (stage_q[1] == stage_q[2]) begin
            lvl_d = stage_q[2];
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            lvl_q <= lvl_d;
        end
    end

    assign lvl_o = lvl_q;

endmodule // plcp_in_sync

// ### plcp_tick.sv
// Purpose: internal time base, one pulse per tick period
// Assumes: single clock
// Notes:   period is a parameter so simulation can shorten it
module plcp_tick #(
    parameter int unsigned CYCLES = 400000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // tick pulse
    output logic tick_o
);

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_d;
    logic tick_q;

    // free-running divider
    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d = tick_d ? '0 : cnt_q + CW'(1);
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule // plcp_tick

// ### plcp_cmd_port.sv
// Purpose: pulse-length command decoder and stroke sequencer
// Assumes: motor handshake and cartridge signals are on clk_i
// Notes:   command pin is asynchronous and is synchronised here
module plcp_cmd_port
    import plcp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command pin from controller
    input wire logic cmd_i,
    // motor drive handshake
    input wire logic motor_done_i,
    input wire logic motor_fault_i,
    output logic motor_run_o,
    output logic first_pump_body_o,
    output logic second_pump_body_o,
    // cartridge
    input wire logic cartridge_new_i,
    output logic pre_warning_o,
    // status pin to controller
    output logic status_o,
    output logic error_o
);

    // ------------------------------------------------------------------
    // pulse window check
    // ------------------------------------------------------------------

    // true when a length in ticks lies inside nominal +/- tolerance
    function automatic logic in_window(input logic [LEN_W-1:0] len,
                                       input int unsigned nom_ms);
        int unsigned lo;
        int unsigned hi;
        lo = (nom_ms - CMD_TOL_MS + TICK_MS - 1) / TICK_MS;
        hi = (nom_ms + CMD_TOL_MS) / TICK_MS;
        return (int'(len) >= lo) && (int'(len) <= hi);
    endfunction

    // maps a measured length onto a command code
    function automatic plcp_cmd_t decode(input logic [LEN_W-1:0] len);
        plcp_cmd_t c;
        c = CMD_NONE;
        if (in_window(len, CMD_PUMP1_MS)) begin
            c = CMD_PUMP1;
        end else if (in_window(len, CMD_PUMP2_MS)) begin
            c = CMD_PUMP2;
        end else if (in_window(len, CMD_BOTH_MS)) begin
            c = CMD_BOTH;
        end else if (in_window(len, CMD_FILL_MS)) begin
            c = CMD_FILL;
        end else if (in_window(len, CMD_ACK_MS)) begin
            c = CMD_ACK;
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic tick;
    logic cmd_lvl;
    logic rise;
    logic fall;
    plcp_cmd_t cmd;

    logic cmd_prev_q, cmd_prev_d;
    logic [LEN_W-1:0] len_q, len_d;
    logic armed_q, armed_d;

    plcp_state_t state_q, state_d;
    logic [TMR_W-1:0] timer_q, timer_d;
    logic [RUN_W-1:0] runs_q, runs_d;
    logic sel2_q, sel2_d;
    logic [STK_W-1:0] strokes_q, strokes_d;

    logic status_q, status_d;
    logic motor_q, motor_d;
    logic pump1_q, pump1_d;
    logic pump2_q, pump2_d;
    logic err_q, err_d;
    logic warn_q, warn_d;

    // ------------------------------------------------------------------
    // time base and pin conditioning
    // ------------------------------------------------------------------

    // 10 ms tick for pulse measurement and all waits
    plcp_tick #(
        .CYCLES(TICK_CYCLES_P)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // command pin is asynchronous to the clock
    plcp_in_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(cmd_i),
        .lvl_o(cmd_lvl)
    );

    // ------------------------------------------------------------------
    // pulse measurement
    // ------------------------------------------------------------------

    // length counter saturates past the stuck limit, so it never decodes
    always_comb begin
        cmd_prev_d = cmd_lvl;
        rise = cmd_lvl & ~cmd_prev_q;
        fall = ~cmd_lvl & cmd_prev_q;
        len_d = len_q;
        if (rise) begin
            len_d = '0;
        end else if (cmd_lvl && tick && len_q != LEN_MAX) begin
            len_d = len_q + LEN_W'(1);
        end
        // a pulse counts only if it began while commands were accepted
        armed_d = armed_q;
        if (rise) begin
            armed_d = (state_q == ST_READY) || (state_q == ST_ERROR);
        end else if (fall) begin
            armed_d = 1'b0;
        end
        // decode on the falling edge only
        cmd = CMD_NONE;
        if (fall && armed_q) begin
            cmd = decode(len_q);
        end
    end

    // measurement registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_prev_q <= 1'b0;
            len_q <= '0;
            armed_q <= 1'b0;
        end else begin
            cmd_prev_q <= cmd_prev_d;
            len_q <= len_d;
            armed_q <= armed_d;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------

    // next state, run plan and stroke bookkeeping
    always_comb begin
        state_d = state_q;
        runs_d = runs_q;
        sel2_d = sel2_q;
        strokes_d = strokes_q;
        case (state_q)
            ST_SELFCHK: begin
                if (int'(timer_q) >= SELFCHK_T) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                // acknowledge has nothing to clear here and is ignored
                case (cmd)
                    CMD_PUMP1: begin
                        state_d = ST_RUN;
                        runs_d = RUNS_SINGLE;
                        sel2_d = 1'b0;
                    end
                    CMD_PUMP2: begin
                        state_d = ST_RUN;
                        runs_d = RUNS_SINGLE;
                        sel2_d = 1'b1;
                    end
                    CMD_BOTH: begin
                        state_d = ST_RUN;
                        runs_d = RUNS_BOTH;
                        sel2_d = 1'b0;
                    end
                    CMD_FILL: begin
                        state_d = ST_RUN;
                        runs_d = RUNS_FILL;
                        sel2_d = 1'b0;
                    end
                    default: begin
                        state_d = ST_READY;
                    end
                endcase
            end
            ST_RUN: begin
                if (motor_fault_i || int'(timer_q) >= RUN_MAX_T) begin
                    state_d = ST_ERROR;
                end else if (motor_done_i) begin
                    strokes_d = strokes_q + STK_W'(1);
                    if (runs_q == RUNS_SINGLE) begin
                        state_d = ST_HOLDOFF;
                    end else begin
                        state_d = ST_GAP;
                        runs_d = runs_q - RUN_W'(1);
                        sel2_d = ~sel2_q;
                    end
                end
            end
            ST_GAP: begin
                if (motor_fault_i) begin
                    state_d = ST_ERROR;
                end else if (int'(timer_q) >= GAP_T) begin
                    state_d = ST_RUN;
                end
            end
            ST_HOLDOFF: begin
                if (motor_fault_i) begin
                    state_d = ST_ERROR;
                end else if (int'(timer_q) > HOLDOFF_T) begin
                    state_d = ST_READY;
                end
            end
            ST_ERROR: begin
                if (cmd == CMD_ACK) begin
                    state_d = ST_HOLDOFF;
                end
            end
            default: begin
                state_d = ST_SELFCHK;
            end
        endcase
        // a new cartridge restarts the stroke count
        if (cartridge_new_i) begin
            strokes_d = '0;
        end else if (strokes_d == '1) begin
            strokes_d = strokes_q;
        end
    end

    // phase timer restarts on every state change
    always_comb begin
        timer_d = timer_q;
        if (state_d != state_q) begin
            timer_d = '0;
        end else if (tick && timer_q != TMR_MAX) begin
            timer_d = timer_q + TMR_W'(1);
        end
    end

    // outputs follow the next state, so they change with the transition
    always_comb begin
        status_d = (state_d == ST_READY) || (state_d == ST_GAP) ||
                   (state_d == ST_HOLDOFF);
        motor_d = (state_d == ST_RUN);
        pump1_d = motor_d && !sel2_d;
        pump2_d = motor_d && sel2_d;
        err_d = (state_d == ST_ERROR);
        warn_d = (strokes_d >= WARN_STROKES);
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_SELFCHK;
            timer_q <= '0;
            runs_q <= '0;
            sel2_q <= 1'b0;
            strokes_q <= '0;
            status_q <= 1'b0;
            motor_q <= 1'b0;
            pump1_q <= 1'b0;
            pump2_q <= 1'b0;
            err_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            runs_q <= runs_d;
            sel2_q <= sel2_d;
            strokes_q <= strokes_d;
            status_q <= status_d;
            motor_q <= motor_d;
            pump1_q <= pump1_d;
            pump2_q <= pump2_d;
            err_q <= err_d;
            warn_q <= warn_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign status_o = status_q;
    assign motor_run_o = motor_q;
    assign first_pump_body_o = pump1_q;
    assign second_pump_body_o = pump2_q;
    assign error_o = err_q;
    assign pre_warning_o = warn_q;

endmodule // plcp_cmd_port

// ### plcp_cmd_port_monitor.sv
// Purpose: concurrent checks on the command port outputs
// Assumes: TICK_CYCLES_P equals that of the bound instance
// Notes: bound into every plcp_cmd_port instance
module plcp_cmd_port_monitor
    import plcp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // port inputs
    input wire logic cmd_i,
    input wire logic motor_done_i,
    input wire logic motor_fault_i,
    input wire logic cartridge_new_i,
    // port outputs
    input wire logic motor_run_o,
    input wire logic first_pump_body_o,
    input wire logic second_pump_body_o,
    input wire logic pre_warning_o,
    input wire logic status_o,
    input wire logic error_o
);
    localparam int T = TICK_CYCLES_P;
    localparam int SAT = 1000000;
    localparam int GAP_LO = (GAP_T - 2) * T;
    localparam int GAP_HI = (GAP_T + 2) * T;
    localparam int IDLE_MIN = HOLDOFF_T * T;
    localparam int RUN_HI = (RUN_MAX_T + 2) * T;
    int since_d, since_q, low_d, low_q, run_d, run_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // cycles since reset, since the motor stopped, and of the current run
    always_comb begin
        since_d = (since_q < SAT) ? since_q + 1 : since_q;
        low_d = motor_run_o ? 0 : ((low_q < SAT) ? low_q + 1 : low_q);
        run_d = !motor_run_o ? 0 : ((run_q < SAT) ? run_q + 1 : run_q);
    end

    // helper registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_q <= 0;
            low_q <= 0;
            run_q <= 0;
        end else begin
            since_q <= since_d;
            low_q <= low_d;
            run_q <= run_d;
        end
    end

    run_status_low_a: assert property (motor_run_o |-> !status_o)
        else $error("status high during motor run");
    error_status_low_a: assert property (
        error_o |-> !status_o && !motor_run_o)
        else $error("status or motor active while error held");
    pump_select_a: assert property (
        motor_run_o == (first_pump_body_o || second_pump_body_o)
        && !(first_pump_body_o && second_pump_body_o))
        else $error("pump body select wrong");
    done_ends_run_a: assert property (
        motor_run_o && motor_done_i && !motor_fault_i
        |=> !motor_run_o && status_o)
        else $error("run did not end high on done");
    fault_latches_a: assert property (
        motor_run_o && motor_fault_i |=> error_o [*3])
        else $error("fault in run not held");
    gap_length_a: assert property (
        $rose(motor_run_o) |-> (low_q >= GAP_LO && low_q <= GAP_HI)
        || low_q > IDLE_MIN)
        else $error("run started at wrong spacing");
    run_bounded_a: assert property (run_q <= RUN_HI)
        else $error("motor run beyond maximum");
    selfcheck_low_a: assert property (
        since_q < (SELFCHK_T - 2) * T |-> !status_o)
        else $error("status high during self-check");
    ready_after_check_a: assert property (
        since_q == (SELFCHK_T + 3) * T |-> status_o)
        else $error("not ready after self-check");
    error_clear_a: assert property ($fell(error_o) |-> status_o)
        else $error("error cleared without ready");
    start_on_fall_a: assert property ($rose(motor_run_o) |-> !cmd_i)
        else $error("run started with command high");
    new_cart_a: assert property (
        cartridge_new_i |=> !pre_warning_o)
        else $error("pre-warning after new cartridge");
endmodule // plcp_cmd_port_monitor

bind plcp_cmd_port plcp_cmd_port_monitor #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_i(cmd_i),
    .motor_done_i(motor_done_i),
    .motor_fault_i(motor_fault_i),
    .cartridge_new_i(cartridge_new_i),
    .motor_run_o(motor_run_o),
    .first_pump_body_o(first_pump_body_o),
    .second_pump_body_o(second_pump_body_o),
    .pre_warning_o(pre_warning_o),
    .status_o(status_o),
    .error_o(error_o)
);

// ### plcp_plc_model.sv
// Purpose: controller and motor stand-in for the command port
// Assumes: pins driven off the falling clock edge, status counted on the rising edge
// Notes: send() keeps the ready wait unless told to be rude
module plcp_plc_model
    import plcp_pkg::*;
#(
    parameter int TCK = 4
) (
    // clock
    input wire logic clk_i,
    // status pin and motor drive from the port
    input wire logic status_i,
    input wire logic motor_run_i,
    // command pin and motor answers
    output logic cmd_o,
    output logic motor_done_o,
    output logic motor_fault_o
);
    localparam int RUN_CLK = 10;
    bit fault_mode = 1'h0;
    // when set the motor never answers, so the port must time the run out
    bit stall_mode = 1'h0;
    int hi_cnt = 0;

    // length of the current high stretch on the status pin
    always @(posedge clk_i) hi_cnt <= (status_i === 1'h1) ? hi_cnt + 1 : 0;

    // wait until status has stood high past the hold-off
    task automatic wait_ready();
        while (hi_cnt <= (HOLDOFF_T + 2) * TCK) begin
            @(negedge clk_i);
        end
    endtask

    // one command pulse of whole ticks, then the pause
    task automatic send(input int ticks, input int pause, input bit polite);
        if (polite) wait_ready();
        @(negedge clk_i);
        cmd_o = 1'h1;
        repeat (ticks * TCK) @(negedge clk_i);
        cmd_o = 1'h0;
        repeat (pause * TCK) @(negedge clk_i);
    endtask

    // motor answers each run with done, with fault when told to, or not at all in stall mode
    initial begin
        cmd_o = 1'h0;
        motor_done_o = 1'h0;
        motor_fault_o = 1'h0;
        forever begin
            @(posedge motor_run_i);
            repeat (RUN_CLK) @(negedge clk_i);
            if (fault_mode) motor_fault_o = 1'h1;
            else if (!stall_mode) motor_done_o = 1'h1;
            @(negedge clk_i);
            motor_done_o = 1'h0;
            motor_fault_o = 1'h0;
        end
    end
endmodule // plcp_plc_model

// ### plcp_cmd_port_tb.sv
// Purpose: self-checking bench for the pulse-length command port
// Assumes: time base shortened to 2 clocks a tick
// Notes: controller and motor come from plcp_plc_model
module plcp_cmd_port_tb
    import plcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TCK = 2;
    typedef struct {int len; int pause; int runs; bit start2;} plcp_row_t;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cartridge_new_i = 1'h0;
    logic cmd_i, motor_done_i, motor_fault_i;
    logic motor_run_o, first_pump_body_o, second_pump_body_o;
    logic pre_warning_o, status_o, error_o;
    logic run_q = 1'h0;
    bit start2 = 1'h0;
    int n_runs = 0;
    int n_pump_bad = 0;
    int n_errors = 0;
    int tests_run = 0;
    plcp_row_t rows [8] = '{
        '{191, 2200, 1, 1'h0},
        '{209, 2200, 1, 1'h0},
        '{500, 2500, 1, 1'h1},
        '{800, 4700, 2, 1'h0},
        '{1200, 200, 80, 1'h0},
        '{1450, 200, 0, 1'h0},
        '{1400, 200, 0, 1'h0},
        '{1600, 200, 0, 1'h0}
    };

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    plcp_cmd_port #(.TICK_CYCLES_P(TCK)) DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cmd_i(cmd_i),
        .motor_done_i(motor_done_i),
        .motor_fault_i(motor_fault_i),
        .motor_run_o(motor_run_o),
        .first_pump_body_o(first_pump_body_o),
        .second_pump_body_o(second_pump_body_o),
        .cartridge_new_i(cartridge_new_i),
        .pre_warning_o(pre_warning_o),
        .status_o(status_o),
        .error_o(error_o)
    );

    plcp_plc_model #(.TCK(TCK)) plc (
        .clk_i(clk_i),
        .status_i(status_o),
        .motor_run_i(motor_run_o),
        .cmd_o(cmd_i),
        .motor_done_o(motor_done_i),
        .motor_fault_o(motor_fault_i)
    );

    // count run starts and check pump bodies alternate
    always @(posedge clk_i) begin
        run_q <= motor_run_o;
        if (motor_run_o === 1'h1 && run_q === 1'h0) begin
            if ({first_pump_body_o, second_pump_body_o} !==
                ((n_runs[0] ^ start2) ? 2'h1 : 2'h2)) n_pump_bad++;
            n_runs++;
        end
    end

    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // cut a hang short
    initial begin
        repeat (95000) @(posedge clk_i);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    // reset, command table, then hold-off and error cases
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'h0;
        check(status_o === 1'h0 && error_o === 1'h0, "reset outputs");
        repeat ((SELFCHK_T - 10) * TCK) @(negedge clk_i);
        check(status_o === 1'h0 && pre_warning_o === 1'h0, "check");
        cartridge_new_i = 1'h1;
        @(negedge clk_i);
        cartridge_new_i = 1'h0;
        repeat (20 * TCK) @(negedge clk_i);
        check(status_o === 1'h1 && pre_warning_o === 1'h0, "ready");
        foreach (rows[i]) begin
            n_runs = 0;
            n_pump_bad = 0;
            start2 = rows[i].start2;
            plc.send(rows[i].len, rows[i].pause, 1'h1);
            plc.wait_ready();
            check(n_runs == rows[i].runs && n_pump_bad == 0, "runs");
        end
        n_runs = 0;
        start2 = 1'h0;
        plc.send(200, 20, 1'h1);
        plc.send(200, 300, 1'h0);
        check(n_runs == 1, "command taken in hold-off");
        plc.fault_mode = 1'h1;
        plc.send(200, 20, 1'h1);
        plc.fault_mode = 1'h0;
        check(error_o === 1'h1 && status_o === 1'h0, "fault not held");
        plc.send(200, 20, 1'h0);
        check(n_runs == 2 && error_o === 1'h1, "stroke in error");
        plc.send(1400, 20, 1'h0);
        check(error_o === 1'h0 && status_o === 1'h1, "ack refused");
        plc.send(200, 20, 1'h1);
        plc.wait_ready();
        check(n_runs == 3, "no run after ack");
        // motor that never finishes: the run must end in error
        plc.stall_mode = 1'h1;
        plc.send(200, 20, 1'h1);
        repeat ((RUN_MAX_T + 10) * TCK) @(negedge clk_i);
        plc.stall_mode = 1'h0;
        check(n_runs == 4 && error_o === 1'h1, "run not timed out");
        check(motor_run_o === 1'h0 && status_o === 1'h0, "timeout");
        plc.send(1400, 20, 1'h0);
        check(error_o === 1'h0 && status_o === 1'h1, "ack after timeout");
        final_report();
    end
endmodule // plcp_cmd_port_tb
